// *** rdt_access.sv ***
// receive descriptor table host access: axi4-lite registers, access sequencer,
// table storage and interrupt; the reception engine sits outside on the eng* ports
// assumes ref_clk at 10 MHz, engine ports on the same clock, reset_n asynchronous
`default_nettype none
`include "rdt_regs.svh"
module rdt_access
    import rdt_pkg::*;
#(
    parameter int DEPTH = 1024,
    parameter int IDX_W = 10
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`RDT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`RDT_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic [IDX_W-1:0] engRdIndex,
    output logic [15:0] engEntry,
    output logic [1:0] engType,
    input wire logic engWrEn,
    input wire logic [IDX_W-1:0] engWrIndex,
    input wire logic [15:0] engWrEntry,
    input wire logic [1:0] engWrType,
    output logic irq
);
    logic [1:0] rstSync_q;
    logic rstN;
    rdt_main_type s_q, s_d;
    logic hostWe, memWe, doneEvt, statClr, maskWe;
    logic [IDX_W-1:0] memWaddr;
    logic [17:0] memWdata, hostRd, engRd;
    logic [`RDT_IRQ_N-1:0] irqStatus, irqMask;
    logic arTake;

    // decode shared by the read and the write path
    function automatic rdt_sel_type regSel(input logic [`RDT_ADDR_W-1:0] a);
        unique case (a)
            `RDT_OFS_RDATA: regSel = RDT_SEL_RDATA;
            `RDT_OFS_WDATA: regSel = RDT_SEL_WDATA;
            `RDT_OFS_CTRL: regSel = RDT_SEL_CTRL;
            `RDT_OFS_ISTAT: regSel = RDT_SEL_ISTAT;
            `RDT_OFS_IMASK: regSel = RDT_SEL_IMASK;
            default: regSel = RDT_SEL_NONE;
        endcase
    endfunction : regSel

    // apply the two low byte strobes to a 16-bit register
    function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                              input logic [31:0] d, input logic [3:0] st);
        laneMerge = old;
        if (st[0]) laneMerge[7:0] = d[7:0];
        if (st[1]) laneMerge[15:8] = d[15:8];
    endfunction : laneMerge

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    // engine write has priority; a host write waits in issue meanwhile
    assign hostWe = (s_q.st == RDT_ISSUE) && s_q.wrSel && !engWrEn; // R9
    assign memWe = engWrEn || hostWe;
    assign memWaddr = engWrEn ? engWrIndex : s_q.index;
    assign memWdata = engWrEn ? {engWrType, engWrEntry} : {s_q.aalType, s_q.wrData}; // R9
    assign doneEvt = (s_q.st == RDT_DONE); // R10 R12

    rdt_table_mem #(
        .DEPTH(DEPTH),
        .IDX_W(IDX_W),
        .WIDTH(18)
    ) u_table (
        .ref_clk(ref_clk),
        .rstN(rstN),
        .ce(ce),
        .we(memWe),
        .wIdx(memWaddr),
        .wData(memWdata),
        .aIdx(s_q.index),
        .aData(hostRd),
        .bIdx(engRdIndex),
        .bData(engRd)
    );

    // the engine sees written flags and acts on them: rx-on, watch, drop, pointer
    assign engEntry = engRd[15:0]; // R2 R3 R4 R5 R6 R7 R8
    assign engType = engRd[17:16];

    rdt_irq u_irq (
        .ref_clk(ref_clk),
        .rstN(rstN),
        .ce(ce),
        .evt(doneEvt),
        .readClr(statClr),
        .maskWe(maskWe),
        .maskData(s_q.wData[`RDT_IRQ_N-1:0]),
        .status(irqStatus),
        .mask(irqMask),
        .irq(irq)
    );

    assign arTake = s_axi_arvalid && s_axi_arready;
    assign statClr = arTake && (regSel(s_axi_araddr) == RDT_SEL_ISTAT);
    assign maskWe = s_q.awHeld && s_q.wHeld && !s_q.bValid
                    && (regSel(s_q.awAddr) == RDT_SEL_IMASK) && s_q.wStrb[0];

    // handshake outputs straight from state, data outputs from flops
    assign s_axi_awready = !s_q.awHeld && !s_q.bValid;
    assign s_axi_wready = !s_q.wHeld && !s_q.bValid;
    assign s_axi_arready = !s_q.rValid;
    assign s_axi_bvalid = s_q.bValid;
    assign s_axi_bresp = s_q.bResp;
    assign s_axi_rvalid = s_q.rValid;
    assign s_axi_rdata = s_q.rData;
    assign s_axi_rresp = s_q.rResp;

    // bus slave and access sequencer
    always_comb begin
        s_d = s_q;
        // address and data are taken in either order and held until both are in
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.awHeld = 1'b1;
            s_d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.wHeld = 1'b1;
            s_d.wData = s_axi_wdata;
            s_d.wStrb = s_axi_wstrb;
        end
        if (s_q.bValid && s_axi_bready) begin
            s_d.bValid = 1'b0;
        end
        if (s_q.awHeld && s_q.wHeld && !s_q.bValid) begin
            s_d.awHeld = 1'b0;
            s_d.wHeld = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp = `RDT_RESP_OKAY;
            unique case (regSel(s_q.awAddr))
                RDT_SEL_WDATA: s_d.wrData = laneMerge(s_q.wrData, s_q.wData, s_q.wStrb);
                RDT_SEL_CTRL: begin
                    // a control write during an access is dropped; the host waits
                    if (!s_q.req) begin // R15
                        if (s_q.wStrb[0]) begin
                            s_d.index[7:0] = s_q.wData[7:0];
                        end
                        if (s_q.wStrb[1]) begin
                            s_d.index[9:8] = s_q.wData[`RDT_CTRL_IDX_MSB:8];
                            s_d.aalType = {s_q.wData[`RDT_CTRL_TYP1], s_q.wData[`RDT_CTRL_TYP0]};
                            s_d.wrSel = s_q.wData[`RDT_CTRL_WRSEL];
                            s_d.req = s_q.wData[`RDT_CTRL_REQ];
                        end
                    end
                end
                RDT_SEL_RDATA, RDT_SEL_ISTAT, RDT_SEL_IMASK: begin
                end
                RDT_SEL_NONE: s_d.bResp = `RDT_RESP_SLVERR;
            endcase
        end
        if (s_q.rValid && s_axi_rready) begin
            s_d.rValid = 1'b0;
        end
        if (arTake) begin
            s_d.rValid = 1'b1;
            s_d.rResp = `RDT_RESP_OKAY;
            s_d.rData = 32'h0000_0000;
            unique case (regSel(s_axi_araddr))
                RDT_SEL_RDATA: s_d.rData[15:0] = s_q.rdData; // R1
                RDT_SEL_WDATA: s_d.rData[15:0] = s_q.wrData;
                RDT_SEL_CTRL: s_d.rData[15:0] = {s_q.req, s_q.wrSel, s_q.aalType[0],
                                                 s_q.aalType[1], 2'h0, s_q.index};
                RDT_SEL_ISTAT: s_d.rData[`RDT_IRQ_N-1:0] = irqStatus;
                RDT_SEL_IMASK: s_d.rData[`RDT_IRQ_N-1:0] = irqMask;
                RDT_SEL_NONE: s_d.rResp = `RDT_RESP_SLVERR;
            endcase
        end
        // access sequencer
        unique case (s_q.st)
            RDT_IDLE: begin
                if (s_q.req) begin
                    s_d.st = RDT_ISSUE;
                end
            end
            RDT_ISSUE: begin
                if (!s_q.wrSel) begin
                    s_d.st = RDT_WAIT; // R11
                end else if (!engWrEn) begin
                    s_d.st = RDT_DONE;
                end
            end
            RDT_WAIT: begin
                s_d.rdData = hostRd[15:0]; // R12
                s_d.st = RDT_DONE;
            end
            RDT_DONE: begin
                s_d.req = 1'b0; // R14
                s_d.st = RDT_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstN || !ce);

    sequence readIssued;
        (s_q.st == RDT_ISSUE) && !s_q.wrSel;
    endsequence

    sequence readCaptured;
        s_q.rdData == $past(hostRd[15:0]);
    endsequence

    a_read_load_reg: assert property (readIssued ##1 1'b1 |=> readCaptured) // R12
        else $error("read-data register not loaded from table");
    a_read_no_store: assert property (readIssued |-> !hostWe ##1 (s_q.st == RDT_WAIT)) // R11
        else $error("read request wrote the table or skipped the wait");
    a_write_store_entry: assert property (hostWe |-> memWaddr == s_q.index
        && memWdata == {s_q.aalType, s_q.wrData} && s_q.req) // R9
        else $error("table write with wrong index or data");
    a_done_clears_req: assert property ((s_q.st == RDT_DONE) |=> !s_q.req
        && s_q.st == RDT_IDLE) // R14
        else $error("request bit not cleared at completion");
    a_req_finishes: assert property ($rose(s_q.req) && !s_q.wrSel |-> ##[3:4] !s_q.req) // R11
        else $error("read access did not finish in time");
    a_write_then_irq: assert property (hostWe |=> doneEvt ##1 irqStatus[`RDT_IRQ_DONE]) // R10
        else $error("write completion interrupt missing");
    a_engine_sees_write: assert property (hostWe ##1 (engRdIndex == $past(memWaddr))
        |=> engEntry == $past(memWdata[15:0], 2)) // R6 R7 R8
        else $error("engine port does not show written flags");
    a_bresp_after_both: assert property ($rose(s_q.bValid) |-> $past(s_q.awHeld && s_q.wHeld)
        )
        else $error("write response before address and data");
endmodule : rdt_access
`default_nettype wire

// *** rdt_access_tb.sv ***
// testbench for rdt_access: axi4-lite register tasks, table write/read, engine port checks
// assumes rdt_regs.svh on the include path and rdt_pkg compiled before this file
`default_nettype none
`include "rdt_regs.svh"
module rdt_access_tb
    import rdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, engWrEn, ce;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, engType, engWrType;
    logic [9:0] engRdIndex, engWrIndex;
    logic [15:0] engEntry, engWrEntry;
    logic [33:0] rdQ[$];
    logic [1:0] wrQ[$];
    logic [33:0] note;
    logic [9:0] idx[8];
    logic [15:0] ent[8];
    logic [15:0] pat[4] = '{16'h8004, 16'h4000, 16'h0002, 16'h0001};
    int fails = 0;
    int nTests = 0;
    int seed = 47210;

    // the prot inputs are tied: they carry no documented behaviour
    rdt_access i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .engRdIndex(engRdIndex), .engEntry(engEntry),
        .engType(engType), .engWrEn(engWrEn), .engWrIndex(engWrIndex),
        .engWrEntry(engWrEntry), .engWrType(engWrType), .irq(irq)
    );

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic end_sim();
        if (fails == 0 && nTests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // control word: type code bit0 sits above code bit1
    function automatic logic [31:0] ctl(logic rq, logic wr, logic [1:0] ty, logic [9:0] ix);
        return {16'h0000, rq, wr, ty[0], ty[1], 2'h0, ix};
    endfunction : ctl

    // one write; address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        int n;
        aw = 1'b0;
        w = 1'b0;
        n = 0;
        wrQ.push_back(er);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        bready <= 1'b1;
        while (!(aw && w) && n < 50) begin
            @(posedge ref_clk);
            n++;
            if (awvalid && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge ref_clk);
            n++;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        if (n >= 50) fails++;
        // spare edge so the next task never reassigns a signal in the same step
        @(posedge ref_clk);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        rdQ.push_back({er, ed});
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (!arready && n < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (!rvalid && n < 50);
        rready <= 1'b0;
        if (n >= 50) fails++;
        @(posedge ref_clk);
    endtask : axi_rd

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        chk("irq", 32'h1, {31'h0, irq});
    endtask : wait_irq

    // engine lookup: entry registered one edge after the index
    task automatic eng_chk(input logic [9:0] ix, input logic [15:0] e, input logic [1:0] t);
        engRdIndex <= ix;
        @(posedge ref_clk);
        @(posedge ref_clk);
        chk("engEntry", {16'h0, e}, {16'h0, engEntry});
        chk("engType", {30'h0, t}, {30'h0, engType});
    endtask : eng_chk

    // watcher: takes the oldest note whenever a bus answer is handed over
    always @(posedge ref_clk) begin
        if (rvalid && rready) begin
            note = rdQ.pop_front();
            chk("rdata", note[31:0], rdata);
            chk("rresp", {30'h0, note[33:32]}, {30'h0, rresp});
        end
        if (bvalid && bready) begin
            chk("bresp", {30'h0, wrQ.pop_front()}, {30'h0, bresp});
        end
    end

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // the sequence needs well under 1500 cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        fails++;
        end_sim();
    end

    initial begin
        {reset_n, awvalid, wvalid, bready, arvalid, rready, engWrEn} = '0;
        ce = 1'b1;
        {awaddr, araddr, wdata, wstrb, engRdIndex, engWrIndex, engWrEntry, engWrType} = '0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // reset values, then an unmapped place both ways
        axi_rd(`RDT_OFS_WDATA, 32'h0, `RDT_RESP_OKAY);
        axi_rd(`RDT_OFS_CTRL, 32'h0, `RDT_RESP_OKAY);
        axi_rd(`RDT_OFS_IMASK, 32'h0, `RDT_RESP_OKAY);
        axi_rd(`RDT_OFS_ISTAT, 32'h0, `RDT_RESP_OKAY);
        axi_rd(8'h14, 32'h0, `RDT_RESP_SLVERR);
        axi_wr(8'h14, 32'hffff, `RDT_RESP_SLVERR);
        axi_wr(`RDT_OFS_IMASK, 32'h1, `RDT_RESP_OKAY);
        // fill entries at both ends of the index range with every type code
        for (int i = 0; i < 8; i++) begin
            idx[i] = (i == 0) ? 10'h000 : (i == 7) ? 10'h3ff : 10'(i * 128 + ($random(seed) & 127));
            ent[i] = (i < 4) ? pat[i] : 16'($random(seed));
            axi_wr(`RDT_OFS_WDATA, {16'h0, ent[i]}, `RDT_RESP_OKAY);
            axi_rd(`RDT_OFS_WDATA, {16'h0, ent[i]}, `RDT_RESP_OKAY);
            axi_wr(`RDT_OFS_CTRL, ctl(1, 1, 2'(i), idx[i]), `RDT_RESP_OKAY);
            wait_irq();
            axi_rd(`RDT_OFS_ISTAT, 32'h1, `RDT_RESP_OKAY);
            chk("irq", 32'h0, {31'h0, irq});
            axi_rd(`RDT_OFS_CTRL, ctl(0, 1, 2'(i), idx[i]), `RDT_RESP_OKAY);
        end
        // read every entry back through the host and the engine side
        for (int i = 0; i < 8; i++) begin
            axi_wr(`RDT_OFS_CTRL, ctl(1, 0, 2'h0, idx[i]), `RDT_RESP_OKAY);
            wait_irq();
            axi_rd(`RDT_OFS_ISTAT, 32'h1, `RDT_RESP_OKAY);
            axi_rd(`RDT_OFS_RDATA, {16'h0, ent[i]}, `RDT_RESP_OKAY);
            eng_chk(idx[i], ent[i], 2'(i));
        end
        // masked completion: status still sticks, cleared by its read
        axi_wr(`RDT_OFS_IMASK, 32'h0, `RDT_RESP_OKAY);
        axi_wr(`RDT_OFS_CTRL, ctl(1, 0, 2'h0, idx[5]), `RDT_RESP_OKAY);
        // a low clock enable freezes the access part way, so the request still shows after it
        ce <= 1'b0;
        repeat (10) @(posedge ref_clk);
        ce <= 1'b1;
        axi_rd(`RDT_OFS_CTRL, ctl(1, 0, 2'h0, idx[5]), `RDT_RESP_OKAY);
        repeat (10) @(posedge ref_clk);
        chk("irq", 32'h0, {31'h0, irq});
        axi_rd(`RDT_OFS_ISTAT, 32'h1, `RDT_RESP_OKAY);
        axi_rd(`RDT_OFS_ISTAT, 32'h0, `RDT_RESP_OKAY);
        axi_rd(`RDT_OFS_RDATA, {16'h0, ent[5]}, `RDT_RESP_OKAY);
        // engine writes stall a host write; a second request meanwhile is dropped
        axi_wr(`RDT_OFS_IMASK, 32'h1, `RDT_RESP_OKAY);
        axi_wr(`RDT_OFS_WDATA, 32'h5a5a, `RDT_RESP_OKAY);
        engWrEn <= 1'b1;
        engWrIndex <= idx[6];
        engWrEntry <= 16'hc3c3;
        engWrType <= 2'h2;
        axi_wr(`RDT_OFS_CTRL, ctl(1, 1, 2'h3, idx[7]), `RDT_RESP_OKAY);
        axi_wr(`RDT_OFS_CTRL, ctl(1, 0, 2'h0, idx[1]), `RDT_RESP_OKAY);
        axi_rd(`RDT_OFS_CTRL, ctl(1, 1, 2'h3, idx[7]), `RDT_RESP_OKAY);
        chk("irq", 32'h0, {31'h0, irq});
        engWrEn <= 1'b0;
        wait_irq();
        axi_rd(`RDT_OFS_ISTAT, 32'h1, `RDT_RESP_OKAY);
        axi_rd(`RDT_OFS_CTRL, ctl(0, 1, 2'h3, idx[7]), `RDT_RESP_OKAY);
        eng_chk(idx[6], 16'hc3c3, 2'h2);
        eng_chk(idx[7], 16'h5a5a, 2'h3);
        axi_wr(`RDT_OFS_CTRL, ctl(1, 0, 2'h0, idx[6]), `RDT_RESP_OKAY);
        wait_irq();
        axi_rd(`RDT_OFS_ISTAT, 32'h1, `RDT_RESP_OKAY);
        axi_rd(`RDT_OFS_RDATA, 32'hc3c3, `RDT_RESP_OKAY);
        end_sim();
    end
endmodule : rdt_access_tb
`default_nettype wire

// *** rdt_irq.sv ***
// sticky interrupt status, clear on read, mask, one level output
// assumes events are single-cycle pulses on ref_clk
`default_nettype none
`include "rdt_regs.svh"
module rdt_irq
    import rdt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstN,
    input wire logic ce,
    input wire logic [`RDT_IRQ_N-1:0] evt,
    input wire logic readClr,
    input wire logic maskWe,
    input wire logic [`RDT_IRQ_N-1:0] maskData,
    output logic [`RDT_IRQ_N-1:0] status,
    output logic [`RDT_IRQ_N-1:0] mask,
    output logic irq
);
    rdt_irq_type s_q, s_d;

    // set wins over the read clear so a coincident event survives
    always_comb begin
        s_d = s_q;
        if (readClr) begin
            s_d.status = '0;
        end
        s_d.status = s_d.status | evt;
        if (maskWe) begin
            s_d.mask = maskData;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign status = s_q.status;
    assign mask = s_q.mask;
    assign irq = |(s_q.status & s_q.mask);

    a_irq_sticky_set: assert property (@(posedge ref_clk) disable iff (!rstN || !ce)
        evt[`RDT_IRQ_DONE] |=> status[`RDT_IRQ_DONE]) // R10
        else $error("done event did not set status");
endmodule : rdt_irq
`default_nettype wire

// *** rdt_pkg.sv ***
// types shared by the receive descriptor table access block
// assumes rdt_regs.svh is on the include path
`default_nettype none
`include "rdt_regs.svh"
package rdt_pkg;
    // access sequencer, gray along idle-issue-wait-done
    typedef enum logic [1:0] {
        RDT_IDLE = 2'h0,
        RDT_ISSUE = 2'h1,
        RDT_WAIT = 2'h3,
        RDT_DONE = 2'h2
    } rdt_state_type;

    typedef enum logic [2:0] {
        RDT_SEL_RDATA, RDT_SEL_WDATA, RDT_SEL_CTRL, RDT_SEL_ISTAT, RDT_SEL_IMASK, RDT_SEL_NONE
    } rdt_sel_type;

    typedef struct packed {
        rdt_state_type st;
        logic [15:0] wrData;
        logic req;
        logic wrSel;
        logic [1:0] aalType;
        logic [9:0] index;
        logic [15:0] rdData;
        logic awHeld;
        logic [`RDT_ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } rdt_main_type;

    typedef struct packed {
        logic [`RDT_IRQ_N-1:0] status;
        logic [`RDT_IRQ_N-1:0] mask;
    } rdt_irq_type;
endpackage : rdt_pkg
`default_nettype wire

// *** rdt_regs.svh ***
// constants for the receive descriptor table access block: offsets, fields, reset values
// assumes a 32-bit axi4-lite bus with byte addresses and 16-bit registers in the low lanes
// Operation
// R1 - a read-data register returns one table entry fetched on request
// R2 - each entry holds a 12-bit descriptor pointer and its valid flag
// R3 - each entry's reception-ongoing flag reports reception in progress on the circuit
// R4 - each entry's watch flag reports whether the circuit is actively monitored
// R5 - each entry's drop flag reports a discard in progress on the channel
// R6 - writing an entry with reception-ongoing set marks reception in progress
// R7 - writing an entry with the watch flag set starts monitoring that circuit
// R8 - writing an entry with the drop flag set discards packets on that channel
// R9 - request with write-select stores write data and 2-bit type at the index
// R10 - a finished table write raises the table-done interrupt
// R11 - request with write-select clear reads the entry at the index
// R12 - a finished read loads the read-data register, then raises the interrupt
// R13 - the host should normally write entries only during initialisation
// R14 - the request bit clears when the access finishes, showing completion
// R15 - the host waits for completion before issuing the next request
`ifndef RDT_REGS_SVH
`define RDT_REGS_SVH
`define RDT_ADDR_W 8
`define RDT_OFS_RDATA 8'h00
`define RDT_OFS_WDATA 8'h04
`define RDT_OFS_CTRL 8'h08
`define RDT_OFS_ISTAT 8'h0c
`define RDT_OFS_IMASK 8'h10
// control register fields
`define RDT_CTRL_REQ 15
`define RDT_CTRL_WRSEL 14
`define RDT_CTRL_TYP0 13
`define RDT_CTRL_TYP1 12
`define RDT_CTRL_IDX_MSB 9
// entry fields
`define RDT_ENT_VALID 15
`define RDT_ENT_RXON 14
`define RDT_ENT_PTR_MSB 13
`define RDT_ENT_PTR_LSB 2
`define RDT_ENT_WATCH 1
`define RDT_ENT_DROP 0
// interrupt status/mask bits
`define RDT_IRQ_N 1
`define RDT_IRQ_DONE 0
// reset values
`define RDT_WDATA_RST 16'h0000
`define RDT_CTRL_RST 16'h0000
`define RDT_IMASK_RST 1'h0
// bus responses
`define RDT_RESP_OKAY 2'h0
`define RDT_RESP_SLVERR 2'h2
`endif

// *** rdt_table_mem.sv ***
// descriptor/status table storage: one write port, two registered read ports
// assumes the caller arbitrates the single write port
`default_nettype none
module rdt_table_mem
    import rdt_pkg::*;
#(
    parameter int DEPTH = 1024,
    parameter int IDX_W = 10,
    parameter int WIDTH = 18
) (
    input wire logic ref_clk,
    input wire logic rstN,
    input wire logic ce,
    input wire logic we,
    input wire logic [IDX_W-1:0] wIdx,
    input wire logic [WIDTH-1:0] wData,
    input wire logic [IDX_W-1:0] aIdx,
    output logic [WIDTH-1:0] aData,
    input wire logic [IDX_W-1:0] bIdx,
    output logic [WIDTH-1:0] bData
);
    logic [WIDTH-1:0] table_q [DEPTH];

    // storage has no reset: software initialises every entry it uses
    always_ff @(posedge ref_clk) begin
        if (ce && we) begin
            table_q[wIdx] <= wData;
        end
    end

    // read-before-write on a shared index: the old entry comes out
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            aData <= '0;
            bData <= '0;
        end else if (ce) begin
            aData <= table_q[aIdx];
            bData <= table_q[bIdx];
        end
    end
endmodule : rdt_table_mem
`default_nettype wire
